// ===== core/rtc_consts.svh
/*
 * Constants of the clock status and control block: register indices, field
 * positions, power-on values and timebase counts.
 * Assumes inclusion by bare name from every file that needs a figure.
 */
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// clock and timebase
`define CLK_HZ          50000000
`define TIMEBASE_HZ     32768
`define TICK_DIV        (`CLK_HZ / `TIMEBASE_HZ)
`define LEAD_MS         122
`define LEAD_TICKS      ((`LEAD_MS * `TIMEBASE_HZ + 999) / 1000)
`define UPDATE_TICKS    8
`define CHAIN_LEN       15

// register indices; byte address is four times the index
`define ADDR_W          12
`define IDX_A           10'h00A
`define IDX_B           10'h00B
`define IDX_C           10'h00C
`define IDX_D           10'h00D
`define IDX_XA          10'h04A
`define IDX_XB          10'h04B

// control A fields
`define A_UIP           7
`define A_CHAIN_HOLD    6
`define A_OSC_ON        5
`define A_BANK          4

// control B fields
`define B_SET           7
`define B_PIE           6
`define B_AIE           5
`define B_UIE           4
`define B_RSVD          3
`define B_DM            2
`define B_H24           1
`define B_DSE           0

// extended status fields
`define XA_AUX          7
`define XA_UPDATE_PENDING         6
`define XA_PAB          3
`define XA_WF           1
`define XA_KF           0

// extended control fields
`define XB_ABE          7
`define XB_CS           5
`define XB_PRS          3
`define XB_WIE          1
`define XB_KSE          0

// power-on values
`define A_RST           8'h20
`define B_RST           8'h00
`define XA_RST          8'h08
`define XB_RST          8'hA9

`endif

// ===== core/rtc_pkg.sv
/*
 * Types of the clock status and control block: sequencer states and the
 * packed state records of both modules.
 * Assumes nothing of its surroundings.
 */
package rtc_pkg;

	typedef enum logic [1:0] {
		seq_idle,
		seq_lead,
		seq_busy
	} seq_state_t;

	typedef struct packed {
		logic [15:0] presc;
		logic [14:0] chain;
		seq_state_t  seq;
		logic [3:0]  seq_cnt;
		logic        periodic;
		logic        pending;
		logic        done;
	} timebase_state_t;

	typedef struct packed {
		logic [7:0]  reg_a;
		logic [7:0]  reg_b;
		logic [2:0]  evt;
		logic [7:0]  xa;
		logic [7:0]  xb;
		logic [2:0]  rd_snap;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq_n;
		logic        pwr_n;
		logic        pwr_oe;
		logic        fall_done;
		logic        jump_fwd;
		logic        jump_back;
		logic        upd_strobe;
		logic        main_q;
		logic        kick_q;
		logic        aux_q;
		logic        vrt_q;
	} ctrl_state_t;

endpackage

// ===== core/timebase_if.sv
/*
 * Link between the register block and the timebase.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface timebase_if;
	logic       osc_on;
	logic       chain_hold;
	logic       set_inhibit;
	logic [3:0] rate_sel;
	logic       periodic_pulse;
	logic       update_pending;
	logic       update_done;

	modport ctrl (
		output osc_on,
		output chain_hold,
		output set_inhibit,
		output rate_sel,
		input  periodic_pulse,
		input  update_pending,
		input  update_done
	);

	modport timer (
		input  osc_on,
		input  chain_hold,
		input  set_inhibit,
		input  rate_sel,
		output periodic_pulse,
		output update_pending,
		output update_done
	);
endinterface : timebase_if

// ===== core/rtc_timebase.sv
/*
 * Timebase: prescaler from pclk to the 32 kHz tick, the 15-stage divider,
 * periodic tap edge detect and the once-a-second update sequencer.
 * Assumes the control end drives the timebase_if inputs from flip-flops.
 */
`timescale 1ns/1ps
`include "rtc_consts.svh"

module rtc_timebase #(
	parameter int PRESCALE = `TICK_DIV
) (
	// clock and reset
	input  wire logic     pclk,
	input  wire logic     presetn,
	// control link
	timebase_if.timer     tb
);

	rtc_pkg::timebase_state_t s;
	rtc_pkg::timebase_state_t next_s;

	assign tb.periodic_pulse = s.periodic;
	assign tb.update_pending = s.pending;
	assign tb.update_done    = s.done;

	always_comb begin
		logic       tick;
		logic [3:0] tap;
		logic       tap_ok;
		next_s = s;
		tick = 1'b0;
		tap = 4'h0;
		tap_ok = 1'b0;
		next_s.periodic = 1'b0;
		next_s.done = 1'b0;
		// oscillator off freezes the prescaler and the divider, and sends the sequencer back to idle
		if (tb.osc_on) begin
			tick = (s.presc == 16'(PRESCALE - 1));
			next_s.presc = tick ? 16'h0000 : s.presc + 16'h0001;
		end
		if (tb.chain_hold)
			next_s.chain = 15'h0000;
		else if (tick)
			next_s.chain = s.chain + 15'h0001;
		// rate 1 and 2 reuse the slow taps, 3..15 run from 8 kHz down
		case (tb.rate_sel)
			4'h0: tap_ok = 1'b0;
			4'h1: begin
				tap = 4'h6;
				tap_ok = 1'b1;
			end
			4'h2: begin
				tap = 4'h7;
				tap_ok = 1'b1;
			end
			default: begin
				tap = tb.rate_sel - 4'h2;
				tap_ok = 1'b1;
			end
		endcase
		if (tap_ok && !s.chain[tap] && next_s.chain[tap])
			next_s.periodic = 1'b1;
		case (s.seq)
			rtc_pkg::seq_idle: begin
				if (tick && !tb.set_inhibit &&
				    next_s.chain == 15'((1 << `CHAIN_LEN) - `LEAD_TICKS)) begin
					next_s.seq = rtc_pkg::seq_lead;
					next_s.pending = 1'b1;
				end
			end
			rtc_pkg::seq_lead: begin
				if (tb.set_inhibit) begin
					next_s.seq = rtc_pkg::seq_idle;
					next_s.pending = 1'b0;
				end else if (tick && next_s.chain == 15'h0000) begin
					next_s.seq = rtc_pkg::seq_busy;
					next_s.seq_cnt = 4'h0;
				end
			end
			rtc_pkg::seq_busy: begin
				if (tb.set_inhibit) begin
					next_s.seq = rtc_pkg::seq_idle;
					next_s.pending = 1'b0;
				end else if (tick) begin
					next_s.seq_cnt = s.seq_cnt + 4'h1;
					if (s.seq_cnt == 4'(`UPDATE_TICKS - 1)) begin
						next_s.seq = rtc_pkg::seq_idle;
						next_s.pending = 1'b0;
						next_s.done = 1'b1;
					end
				end
			end
			default: next_s.seq = rtc_pkg::seq_idle;
		endcase
		if (!tb.osc_on || tb.chain_hold) begin
			next_s.seq = rtc_pkg::seq_idle;
			next_s.pending = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

endmodule // rtc_timebase

// ===== core/rtc_status_interrupt_control.sv
/*
 * Status, interrupt-flag and extended control registers of the battery
 * backed clock, reached over APB, with the interrupt and power-request pins.
 * Assumes the time counters, alarm comparators and calendar sit outside and
 * report matches as synchronous levels; presetn marks the first power-up.
 */
`timescale 1ns/1ps
`include "rtc_consts.svh"

module rtc_status_interrupt_control #(
	parameter int PRESCALE = `TICK_DIV
) (
	// clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [`ADDR_W-1:0]   paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// reports from the time and calendar logic
	input  wire logic                 alarm_match,
	input  wire logic                 wake_alarm_match,
	input  wire logic                 dst_spring_point,
	input  wire logic                 dst_fall_point,
	// supplies and pins
	input  wire logic                 main_supply_ok,
	input  wire logic                 aux_supply_pin,
	input  wire logic                 battery_good,
	input  wire logic                 wake_button_in,
	output logic                      irq_out_n,
	output logic                      power_request_n,
	output logic                      power_request_oe,
	// controls to the time and calendar logic
	output logic                      binary_format,
	output logic                      hour_24,
	output logic                      dst_enable,
	output logic                      update_strobe,
	output logic                      dst_jump_fwd,
	output logic                      dst_jump_back,
	// analogue and oscillator controls
	output logic                      aux_supply_enable,
	output logic                      xtal_load_sel,
	output logic                      osc_on,
	output logic                      chain_hold
);

	rtc_pkg::ctrl_state_t s;
	rtc_pkg::ctrl_state_t next_s;

	timebase_if tbl ();

	rtc_timebase #(
		.PRESCALE (PRESCALE)
	) u_timebase (
		.pclk    (pclk),
		.presetn (presetn),
		.tb      (tbl.timer)
	);

	// the timebase sees only flopped controls
	assign tbl.osc_on      = s.reg_a[`A_OSC_ON];
	assign tbl.chain_hold  = s.reg_a[`A_CHAIN_HOLD] & s.reg_a[`A_OSC_ON];
	assign tbl.set_inhibit = s.reg_b[`B_SET];
	assign tbl.rate_sel    = s.reg_a[3:0];

	assign prdata            = s.prdata;
	assign pready            = s.pready;
	assign pslverr           = s.pslverr;
	assign irq_out_n         = s.irq_n;
	assign power_request_n   = s.pwr_n;
	assign power_request_oe  = s.pwr_oe;
	assign binary_format     = s.reg_b[`B_DM];
	assign hour_24           = s.reg_b[`B_H24];
	assign dst_enable        = s.reg_b[`B_DSE];
	assign update_strobe     = s.upd_strobe;
	assign dst_jump_fwd      = s.jump_fwd;
	assign dst_jump_back     = s.jump_back;
	assign aux_supply_enable = s.xb[`XB_ABE];
	assign xtal_load_sel     = s.xb[`XB_CS];
	assign osc_on            = s.reg_a[`A_OSC_ON];
	assign chain_hold        = s.reg_a[`A_CHAIN_HOLD];

	always_comb begin
		logic [9:0] idx;
		logic       bank;
		logic       hit_a;
		logic       hit_b;
		logic       hit_c;
		logic       hit_d;
		logic       hit_xa;
		logic       hit_xb;
		logic       mapped;
		logic       done;
		logic       access;
		logic [7:0] wd;
		logic [7:0] rd;
		logic [2:0] clr;
		logic [2:0] evt_set;
		logic       cur_irq;
		logic       summary;
		logic       kick_fall;

		next_s = s;
		idx = paddr[`ADDR_W-1:2];
		bank = s.reg_a[`A_BANK];
		hit_a = (idx == `IDX_A);
		hit_b = (idx == `IDX_B);
		hit_c = (idx == `IDX_C);
		hit_d = (idx == `IDX_D);
		hit_xa = bank && (idx == `IDX_XA);
		hit_xb = bank && (idx == `IDX_XB);
		mapped = (paddr[1:0] == 2'b00) && (hit_a || hit_b || hit_c || hit_d || hit_xa || hit_xb);
		done = tbl.update_done;
		access = psel && penable && s.pready;
		wd = pwdata[7:0];
		clr = 3'b000;
		rd = 8'h00;
		kick_fall = s.kick_q && !wake_button_in;
		evt_set = {tbl.periodic_pulse, done && alarm_match, done};

		cur_irq = |(s.evt & s.reg_b[`B_PIE:`B_UIE]) ||
		          (s.xa[`XA_WF] && s.xb[`XB_WIE]) ||
		          (s.xa[`XA_KF] && s.xb[`XB_KSE]);

		next_s.jump_fwd = 1'b0;
		next_s.jump_back = 1'b0;
		next_s.upd_strobe = done;
		next_s.main_q = main_supply_ok;
		next_s.kick_q = wake_button_in;
		next_s.aux_q = aux_supply_pin;
		next_s.vrt_q = battery_good;

		// read data is sampled in the setup cycle and held through access
		if (hit_a)
			rd = {tbl.update_pending, s.reg_a[6:0]};
		else if (hit_b)
			rd = {s.reg_b[7:4], 1'b0, s.reg_b[2:0]};
		else if (hit_c)
			rd = {cur_irq, s.evt, 4'h0};
		else if (hit_d)
			rd = {s.vrt_q, 7'h00};
		else if (hit_xa)
			rd = {s.aux_q, tbl.update_pending, s.xa[5:0]};
		else if (hit_xb)
			rd = s.xb;

		if (psel && !penable) begin
			next_s.pready = 1'b1;
			next_s.pslverr = !mapped;
			next_s.prdata = (mapped && !pwrite) ? {24'h000000, rd} : 32'h00000000;
			// only bits shown to software may be cleared by this read
			next_s.rd_snap = (hit_c && !pwrite) ? s.evt : 3'b000;
		end else begin
			next_s.pready = 1'b0;
			next_s.pslverr = 1'b0;
		end

		if (access && mapped && pwrite) begin
			if (hit_a)
				next_s.reg_a[6:0] = wd[6:0];
			if (hit_b) begin
				next_s.reg_b = wd;
				next_s.reg_b[`B_RSVD] = 1'b0;
				if (wd[`B_SET])
					next_s.reg_b[`B_UIE] = 1'b0;
			end
			if (hit_xa)
				next_s.xa[5:0] = wd[5:0];
			if (hit_xb)
				next_s.xb = wd;
		end
		if (access && mapped && !pwrite && hit_c)
			clr = s.rd_snap;

		// a set in the clearing cycle wins
		next_s.evt = (s.evt & ~clr) | evt_set;
		if (done && wake_alarm_match)
			next_s.xa[`XA_WF] = 1'b1;
		if (kick_fall && s.xb[`XB_KSE])
			next_s.xa[`XA_KF] = 1'b1;

		if ((next_s.xa[`XA_WF] && next_s.xb[`XB_WIE]) || (next_s.xa[`XA_KF] && next_s.xb[`XB_KSE]))
			next_s.xa[`XA_PAB] = 1'b0;

		// main supply returning counts as a power-on
		if (main_supply_ok && !s.main_q) begin
			next_s.reg_a[`A_OSC_ON] = 1'b1;
			next_s.reg_a[`A_CHAIN_HOLD] = 1'b0;
		end

		if (done && s.reg_b[`B_DSE]) begin
			if (dst_spring_point) begin
				next_s.jump_fwd = 1'b1;
				next_s.fall_done = 1'b0;
			end
			// the repeated hour must not step back a second time
			if (dst_fall_point && !s.fall_done) begin
				next_s.jump_back = 1'b1;
				next_s.fall_done = 1'b1;
			end
		end

		summary = |(next_s.evt & next_s.reg_b[`B_PIE:`B_UIE]) ||
		          (next_s.xa[`XA_WF] && next_s.xb[`XB_WIE]) ||
		          (next_s.xa[`XA_KF] && next_s.xb[`XB_KSE]);
		// with main supply absent the interrupt waits, the power pin does not if XB_PRS is set
		next_s.irq_n = !(summary && main_supply_ok);
		next_s.pwr_n = next_s.xa[`XA_PAB];
		next_s.pwr_oe = main_supply_ok || next_s.xb[`XB_PRS];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.reg_a <= `A_RST;
			s.reg_b <= `B_RST;
			s.xa <= `XA_RST;
			s.xb <= `XB_RST;
			s.irq_n <= 1'b1;
			s.pwr_n <= 1'b1;
			s.pwr_oe <= 1'b1;
			s.kick_q <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

endmodule // rtc_status_interrupt_control

// ===== tb/rtc_status_monitor.sv
/* checker on the ports of the clock status block
   assumes bind onto rtc_status_interrupt_control, single pclk domain */
`timescale 1ns/1ps
`include "rtc_consts.svh"

module rtc_status_monitor (
	// clock and reset
	input wire logic                pclk,
	input wire logic                presetn,
	// apb
	input wire logic                psel,
	input wire logic                penable,
	input wire logic [`ADDR_W-1:0]  paddr,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	// pins and controls
	input wire logic                main_supply_ok,
	input wire logic                irq_out_n,
	input wire logic                power_request_oe,
	input wire logic                dst_enable,
	input wire logic                update_strobe,
	input wire logic                dst_jump_fwd,
	input wire logic                dst_jump_back,
	input wire logic                osc_on,
	input wire logic                chain_hold
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	ready_one_cycle_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready is not a single access cycle");
	error_data_zero_a: assert property (pready && pslverr |-> prdata == 32'h00000000)
		else $error("refused access returned data");
	upper_bytes_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("read data above the byte not zero");
	status_low_zero_a: assert property (pready && !pslverr && paddr[11:2] == `IDX_C |-> prdata[3:0] == 4'h0)
		else $error("interrupt status low nibble not zero");
	battery_low_zero_a: assert property (pready && !pslverr && paddr[11:2] == `IDX_D |-> prdata[6:0] == 7'h00)
		else $error("battery status low bits not zero");
	irq_needs_main_a: assert property (!main_supply_ok |=> irq_out_n)
		else $error("interrupt pin active without main supply");
	pin_driven_main_a: assert property (main_supply_ok |=> power_request_oe)
		else $error("power pin floats with main supply present");
	power_on_osc_a: assert property ($rose(main_supply_ok) |-> ##[1:2] (osc_on && !chain_hold))
		else $error("power-on did not start the oscillator chain");
	dst_jump_gate_a: assert property (dst_jump_fwd || dst_jump_back |-> update_strobe && dst_enable)
		else $error("daylight step outside an enabled update");
endmodule // rtc_status_monitor

bind rtc_status_interrupt_control rtc_status_monitor mon_u (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
	.pready, .pslverr, .main_supply_ok, .irq_out_n, .power_request_oe, .dst_enable, .update_strobe,
	.dst_jump_fwd, .dst_jump_back, .osc_on, .chain_hold);

// ===== tb/apb_host.sv
/* host processor model: single apb transfers
   assumes an apb slave clocked by pclk, answering with pready */
`timescale 1ns/1ps
`include "rtc_consts.svh"

module apb_host (
	// clock
	input wire logic                pclk,
	// apb master side
	output logic                    psel,
	output logic                    penable,
	output logic                    pwrite,
	output logic [`ADDR_W-1:0]      paddr,
	output logic [31:0]             pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end

	task automatic xfer(input logic wr, input logic [`ADDR_W-1:0] a, input logic [7:0] d,
		output logic [31:0] rd, output logic err, output logic hung);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		hung = 1'b1;
		// looked at mid-cycle, where the registered answer has settled
		for (n = 0; n < 16 && hung; n++) begin
			@(negedge pclk);
			hung = (pready !== 1'b1);
		end
		rd = prdata;
		err = pslverr;
		// the transfer completes at the next rising edge; release only after it
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines change so a stale value is never mistaken for data
		paddr <= ~a;
		pwdata <= ~{24'h000000, d};
	endtask
endmodule // apb_host

// ===== tb/tb_top.sv
/* self-checking bench of the clock status block
   assumes the apb_host model and the bound port checker */
`timescale 1ns/1ps
`include "rtc_consts.svh"

module tb_top;
	localparam int PRESC = 2;
	localparam logic [11:0] AD_A = {`IDX_A, 2'h0}, AD_B = {`IDX_B, 2'h0}, AD_C = {`IDX_C, 2'h0},
		AD_D = {`IDX_D, 2'h0}, AD_XA = {`IDX_XA, 2'h0}, AD_XB = {`IDX_XB, 2'h0};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic        alarm_match, wake_alarm_match, dst_spring_point, dst_fall_point;
	logic        main_supply_ok, aux_supply_pin, battery_good, wake_button_in;
	logic        irq_out_n, power_request_n, power_request_oe, binary_format, hour_24, dst_enable;
	logic        update_strobe, dst_jump_fwd, dst_jump_back, aux_supply_enable, xtal_load_sel, osc_on, chain_hold;
	int          failures = 0, checked = 0, seed = 32'h741EF8FC, i;
	int          m_aux = 1, m_pab = 1, m_wf = 0, m_kf = 0, m_b;

	rtc_status_interrupt_control #(.PRESCALE(PRESC)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .alarm_match, .wake_alarm_match, .dst_spring_point,
		.dst_fall_point, .main_supply_ok, .aux_supply_pin, .battery_good, .wake_button_in, .irq_out_n,
		.power_request_n, .power_request_oe, .binary_format, .hour_24, .dst_enable, .update_strobe,
		.dst_jump_fwd, .dst_jump_back, .aux_supply_enable, .xtal_load_sel, .osc_on, .chain_hold);
	apb_host host_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

	always #10 pclk = ~pclk;

	function automatic logic [31:0] xa_exp();
		return {24'h000000, m_aux[0], 3'h0, m_pab[0], 1'b0, m_wf[0], m_kf[0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [31:0] e,
		input logic eerr);
		logic [31:0] rd;
		logic        err, hung;
		host_u.xfer(w, a, d, rd, err, hung);
		if (hung) begin
			failures++;
			test_done();
		end
		check({31'h0, err}, {31'h0, eerr});
		if (!w)
			check(rd, e);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		acc(1'b1, a, d, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic eerr);
		acc(1'b0, a, 8'h00, e, eerr);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{alarm_match, wake_alarm_match, dst_spring_point, dst_fall_point} = 4'h0;
		{main_supply_ok, aux_supply_pin, battery_good, wake_button_in} = 4'hF;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check({osc_on, chain_hold, aux_supply_enable, xtal_load_sel, power_request_n, power_request_oe,
			irq_out_n}, 32'h5F);
		rd(AD_XA, 32'h0, 1'b1);
		wr(AD_A, 8'h30);
		rd(AD_XB, 32'hA9, 1'b0);
		rd(AD_XA, xa_exp(), 1'b0);
		m_aux = 0;
		aux_supply_pin <= 1'b0;
		rd(AD_XA, xa_exp(), 1'b0);
		wr(AD_D, 8'hFF);
		rd(AD_D, 32'h80, 1'b0);
		battery_good <= 1'b0;
		rd(AD_D, 32'h0, 1'b0);
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			v = $random(seed);
			// set bit stays readable, and setting it drops the update enable
			m_b = v[7] ? (v & 32'hE7) : (v & 32'hF7);
			wr(AD_B, v[7:0]);
			rd(AD_B, m_b, 1'b0);
			check({binary_format, hour_24, dst_enable}, m_b[2:0]);
		end
		wr(AD_B, 8'h90);
		rd(AD_B, 32'h80, 1'b0);
		wr(AD_B, 8'h00);
		$display("test control done");
		wr(AD_A, 8'h33);
		repeat (40) @(posedge pclk);
		wr(AD_A, 8'h30);
		check(irq_out_n, 32'h1);
		wr(AD_B, 8'h40);
		for (i = 0; i < 20 && irq_out_n !== 1'b0; i++)
			@(posedge pclk);
		check(irq_out_n, 32'h0);
		rd(AD_C, 32'hC0, 1'b0);
		rd(AD_C, 32'h0, 1'b0);
		check(irq_out_n, 32'h1);
		wr(AD_C, 8'hFF);
		rd(AD_C, 32'h0, 1'b0);
		wr(AD_B, 8'h00);
		$display("test interrupt status done");
		wake_button_in <= 1'b0;
		repeat (2) @(posedge pclk);
		check({irq_out_n, power_request_n}, 32'h0);
		m_kf = 1;
		m_pab = 0;
		wake_button_in <= 1'b1;
		rd(AD_XA, xa_exp(), 1'b0);
		wr(AD_XA, 8'h00);
		wr(AD_XA, 8'h08);
		m_kf = 0;
		m_pab = 1;
		rd(AD_XA, xa_exp(), 1'b0);
		check(power_request_n, 32'h1);
		wr(AD_XA, 8'h0A);
		m_wf = 1;
		rd(AD_XA, xa_exp(), 1'b0);
		wr(AD_XA, 8'h08);
		m_wf = 0;
		rd(AD_XA, xa_exp(), 1'b0);
		wr(AD_A, 8'h50);
		main_supply_ok <= 1'b0;
		wake_button_in <= 1'b0;
		repeat (2) @(posedge pclk);
		check({irq_out_n, power_request_n, power_request_oe}, 32'h5);
		main_supply_ok <= 1'b1;
		wake_button_in <= 1'b1;
		repeat (3) @(posedge pclk);
		check({irq_out_n, osc_on, chain_hold}, 32'h2);
		rd(AD_A, 32'h30, 1'b0);
		wr(AD_XA, 8'h00);
		wr(AD_XA, 8'h08);
		$display("test kick and power done");
		wr(AD_XB, 8'hFF);
		rd(AD_XB, 32'hFF, 1'b0);
		wr(AD_XB, 8'hA1);
		main_supply_ok <= 1'b0;
		repeat (2) @(posedge pclk);
		check(power_request_oe, 32'h0);
		main_supply_ok <= 1'b1;
		$display("test fail hold done");
		wr(AD_B, 8'h11);
		alarm_match <= 1'b1;
		dst_spring_point <= 1'b1;
		// one full second of the divider at the bench prescale
		for (i = 0; i < 70000 && update_strobe !== 1'b1; i++)
			@(negedge pclk);
		if (update_strobe !== 1'b1) begin
			failures++;
			test_done();
		end
		check({update_strobe, dst_jump_fwd, dst_jump_back}, 32'h6);
		alarm_match <= 1'b0;
		dst_spring_point <= 1'b0;
		repeat (2) @(posedge pclk);
		check(irq_out_n, 32'h0);
		rd(AD_C, 32'hB0, 1'b0);
		rd(AD_A, 32'h30, 1'b0);
		wr(AD_B, 8'h00);
		$display("test update done");
		test_done();
	end
endmodule // tb_top
